// ---- rtl/aep_chan_integ.sv ----
`timescale 1ns/1ps
`default_nettype none
module aep_chan_integ (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample_en,
  input wire logic [aep_pkg::PWR_W-1:0] power,
  input wire logic [aep_pkg::PWR_W-1:0] gain,
  input wire logic [aep_pkg::PWR_W-1:0] offset,
  input wire logic [aep_pkg::THR_W-1:0] thr,
  output aep_pkg::aep_chan_out_t result
);
  import aep_pkg::*;

  // ==========================================================
  // Gain and offset correction
  logic signed [2*PWR_W-1:0] prod;
  logic signed [SCL_W-1:0] scaled;
  logic signed [ACC_W-1:0] acc;
  logic signed [ACC_W-1:0] sum;
  logic signed [ACC_W-1:0] thr_s;
  logic take_pos;
  logic take_neg;
  logic pulse_pos;
  logic pulse_neg;
  logic [CNT_W-1:0] count;

  // One driver for the whole carrier; the fields come from the flops below
  assign result = {pulse_pos, pulse_neg, count};

  // Gain holds at most 2^23 in magnitude, so the shifted product fits easily
  assign prod = $signed(power) * $signed(gain);
  assign scaled = SCL_W'($signed(power)) + SCL_W'(prod >>> GAIN_FRAC) + SCL_W'($signed(offset));

  // Signed sum against the shared threshold, both directions
  assign sum = acc + ACC_W'(scaled);
  assign thr_s = $signed(ACC_W'(thr));
  assign take_pos = (sum >= thr_s);
  assign take_neg = !take_pos && ((sum + thr_s) <= $signed(ACC_W'(0)));

  // ==========================================================
  // First stage: threshold accumulator, one pulse per sample at most
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
      pulse_pos <= 1'b0;
      pulse_neg <= 1'b0;
    end else begin
      pulse_pos <= sample_en && take_pos;
      pulse_neg <= sample_en && take_neg;
      if (sample_en) begin
        if (take_pos) begin
          acc <= sum - thr_s;
        end else if (take_neg) begin
          acc <= sum + thr_s;
        end else begin
          acc <= sum;
        end
      end
    end
  end

  // Second stage: signed pulse counter, wraps like the readable register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (pulse_pos) begin
      count <= count + CNT_W'(1);
    end else if (pulse_neg) begin
      count <= count - CNT_W'(1);
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  pulse_from_sample_a: assert property ((result.pulse_pos || result.pulse_neg) |-> $past(sample_en))
    else $error("energy pulse without a sample tick");
  pulse_exclusive_a: assert property (!(result.pulse_pos && result.pulse_neg))
    else $error("both pulse directions at once");
  pos_pulse_cause_a: assert property (sample_en && take_pos |=> result.pulse_pos && acc == $past(sum) - $past(thr_s))
    else $error("threshold reached but no pulse or no subtraction");
  count_up_a: assert property (result.pulse_pos |=> result.count == $past(result.count) + CNT_W'(1))
    else $error("counter did not step up on positive pulse");
  count_down_a: assert property (result.pulse_neg |=> result.count == $past(result.count) - CNT_W'(1))
    else $error("counter did not step down on negative pulse");
  neg_pulse_c: cover property (result.pulse_neg);
endmodule
`default_nettype wire

// ---- rtl/aep_pkg.sv ----
package aep_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int SAMPLE_PERIOD_US = 125;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_US * 1000000 / CLK_PERIOD_PS;
  localparam int DIV_W = 16;

  // ==========================================================
  // Datapath widths
  localparam int PWR_W = 28;
  localparam int VAL_W = 24;
  localparam int GAIN_FRAC = 23;
  localparam int SCL_W = 30;
  localparam int THR_W = 48;
  localparam int THR_HALF_W = 24;
  localparam int ACC_W = 50;
  localparam int CNT_W = 32;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 8;
  localparam int NPH = 3;
  localparam int NCH = 6;

  // ==========================================================
  // Register offsets (word indices on the register port)
  localparam logic [ADDR_W-1:0] ADDR_GAIN_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_OFFS_BASE = 8'h06;
  localparam logic [ADDR_W-1:0] ADDR_THR_UPPER = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_THR_LOWER = 8'h0D;
  localparam logic [ADDR_W-1:0] ADDR_SIGN = 8'h0E;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0F;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_ACC_CFG = 8'h11;
  localparam logic [ADDR_W-1:0] ADDR_ENERGY_BASE = 8'h12;

  // ==========================================================
  // Field positions and reset values
  localparam int REV_LSB = 6;
  localparam int SIGN_LSB = 0;
  localparam int REVSEL_BIT = 6;
  localparam logic [PWR_W-1:0] GAIN_RST = 28'h0000000;
  localparam logic [PWR_W-1:0] OFFS_RST = 28'h0000000;
  localparam logic [THR_W-1:0] THR_RST = 48'h000000000000;
  localparam logic [NPH-1:0] FLAGS_RST = 3'h0;
  localparam logic [WORD_W-1:0] WORD_ZERO = 32'h00000000;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [NPH-1:0][PWR_W-1:0] fund;
    logic [NPH-1:0][PWR_W-1:0] total;
  } aep_power_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } aep_reg_req_t;

  typedef struct packed {
    logic pulse_pos;
    logic pulse_neg;
    logic [CNT_W-1:0] count;
  } aep_chan_out_t;
endpackage

// ---- rtl/aep_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module aep_top #(
  parameter int SAMPLE_CYCLES = aep_pkg::SAMPLE_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire aep_pkg::aep_power_t POWER,
  input wire aep_pkg::aep_reg_req_t REG_REQ,
  output logic [aep_pkg::WORD_W-1:0] REG_RDATA,
  output logic REG_RVALID,
  output logic PRIMARY_INTERRUPT_N
);
  import aep_pkg::*;

  // ==========================================================
  // Address decode helpers, shared by the write and read paths
  function automatic logic in_block(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] base);
    return (addr >= base) && (addr < base + ADDR_W'(NCH));
  endfunction

  function automatic logic [2:0] block_idx(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] diff;
    diff = addr - base;
    return diff[2:0];
  endfunction

  // 24-bit signed field is kept sign-extended to the 28-bit internal width
  function automatic logic [PWR_W-1:0] sext_val(input logic [WORD_W-1:0] w);
    return {{(PWR_W-VAL_W){w[VAL_W-1]}}, w[VAL_W-1:0]};
  endfunction

  // ==========================================================
  // Sample tick divider: one pulse per 125 us
  logic [DIV_W-1:0] div_cnt;
  logic sample_en;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_cnt <= '0;
      sample_en <= 1'b0;
    end else if (div_cnt == DIV_W'(SAMPLE_CYCLES - 1)) begin
      div_cnt <= '0;
      sample_en <= 1'b1;
    end else begin
      div_cnt <= div_cnt + DIV_W'(1);
      sample_en <= 1'b0;
    end
  end

  // ==========================================================
  // Calibration and configuration registers
  logic [NCH-1:0][PWR_W-1:0] gain;
  logic [NCH-1:0][PWR_W-1:0] offs;
  logic [THR_W-1:0] thr;
  logic [NPH-1:0] rev_mask;
  logic rev_sel;
  logic wr_status;

  assign wr_status = REG_REQ.wr && (REG_REQ.addr == ADDR_STATUS);

  // Writes take the low 24 bits; the padding nibble is ignored
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      gain <= {NCH{GAIN_RST}};
      offs <= {NCH{OFFS_RST}};
      thr <= THR_RST;
      rev_mask <= FLAGS_RST;
      rev_sel <= 1'b0;
    end else if (REG_REQ.wr) begin
      if (in_block(REG_REQ.addr, ADDR_GAIN_BASE)) begin
        gain[block_idx(REG_REQ.addr, ADDR_GAIN_BASE)] <= sext_val(REG_REQ.wdata);
      end
      if (in_block(REG_REQ.addr, ADDR_OFFS_BASE)) begin
        offs[block_idx(REG_REQ.addr, ADDR_OFFS_BASE)] <= sext_val(REG_REQ.wdata);
      end
      if (REG_REQ.addr == ADDR_THR_UPPER) begin
        thr[THR_W-1:THR_HALF_W] <= REG_REQ.wdata[THR_HALF_W-1:0];
      end
      if (REG_REQ.addr == ADDR_THR_LOWER) begin
        thr[THR_HALF_W-1:0] <= REG_REQ.wdata[THR_HALF_W-1:0];
      end
      if (REG_REQ.addr == ADDR_MASK) begin
        rev_mask <= REG_REQ.wdata[REV_LSB +: NPH];
      end
      if (REG_REQ.addr == ADDR_ACC_CFG) begin
        rev_sel <= REG_REQ.wdata[REVSEL_BIT];
      end
    end
  end

  // ==========================================================
  // Six identical integration channels: 0..2 total A..C, 3..5 fund A..C
  logic [NCH-1:0][PWR_W-1:0] pwr_all;
  aep_chan_out_t ch [NCH];

  assign pwr_all = {POWER.fund, POWER.total};

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    aep_chan_integ u_ch (
      .clk(CLK),
      .rst_n(RST_N),
      .sample_en(sample_en),
      .power(pwr_all[c]),
      .gain(gain[c]),
      .offset(offs[c]),
      .thr(thr),
      .result(ch[c])
    );
  end

  // ==========================================================
  // Sign detection on the selected power type
  logic [NPH-1:0] sel_pulse;
  logic [NPH-1:0] sel_neg;
  logic [NPH-1:0] rev_evt;
  logic [NPH-1:0] phase_sign;
  logic [NPH-1:0] rev_flag;
  logic [NPH-1:0] next_rev_flag;

  // Sign is taken from the direction of the threshold pulse itself
  always_comb begin
    for (int i = 0; i < NPH; i++) begin
      sel_pulse[i] = rev_sel ? (ch[i+NPH].pulse_pos || ch[i+NPH].pulse_neg)
                             : (ch[i].pulse_pos || ch[i].pulse_neg);
      sel_neg[i] = rev_sel ? ch[i+NPH].pulse_neg : ch[i].pulse_neg;
      rev_evt[i] = sel_pulse[i] && (sel_neg[i] != phase_sign[i]);
    end
  end

  // Sign bits move only with a reversal, so flag and sign change together
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      phase_sign <= FLAGS_RST;
    end else begin
      for (int i = 0; i < NPH; i++) begin
        if (rev_evt[i]) begin
          phase_sign[i] <= sel_neg[i];
        end
      end
    end
  end

  // A new reversal beats a write-one clear in the same cycle
  always_comb begin
    for (int i = 0; i < NPH; i++) begin
      next_rev_flag[i] = rev_evt[i] ||
                         (rev_flag[i] && !(wr_status && REG_REQ.wdata[REV_LSB+i]));
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rev_flag <= FLAGS_RST;
    end else begin
      rev_flag <= next_rev_flag;
    end
  end

  // Interrupt pin is registered off the flags, one cycle behind them
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRIMARY_INTERRUPT_N <= 1'b1;
    end else begin
      PRIMARY_INTERRUPT_N <= ~|(rev_flag & rev_mask);
    end
  end

  // ==========================================================
  // Read path
  logic [WORD_W-1:0] rd_word;

  // Energy words are the live counters captured at the read: that is the transfer
  always_comb begin
    rd_word = WORD_ZERO;
    if (in_block(REG_REQ.addr, ADDR_GAIN_BASE)) begin
      rd_word = WORD_W'(gain[block_idx(REG_REQ.addr, ADDR_GAIN_BASE)]);
    end else if (in_block(REG_REQ.addr, ADDR_OFFS_BASE)) begin
      rd_word = WORD_W'(offs[block_idx(REG_REQ.addr, ADDR_OFFS_BASE)]);
    end else if (in_block(REG_REQ.addr, ADDR_ENERGY_BASE)) begin
      rd_word = ch[block_idx(REG_REQ.addr, ADDR_ENERGY_BASE)].count;
    end else begin
      unique case (REG_REQ.addr)
        ADDR_THR_UPPER: rd_word = WORD_W'(thr[THR_W-1:THR_HALF_W]);
        ADDR_THR_LOWER: rd_word = WORD_W'(thr[THR_HALF_W-1:0]);
        ADDR_SIGN: rd_word[SIGN_LSB +: NPH] = phase_sign;
        ADDR_STATUS: rd_word[REV_LSB +: NPH] = rev_flag;
        ADDR_MASK: rd_word[REV_LSB +: NPH] = rev_mask;
        ADDR_ACC_CFG: rd_word[REVSEL_BIT] = rev_sel;
        default: rd_word = WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= WORD_ZERO;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_REQ.rd;
      if (REG_REQ.rd) begin
        REG_RDATA <= rd_word;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  flag_on_rev_a: assert property (rev_evt[0] |=> rev_flag[0])
    else $error("phase A reversal did not set its flag");
  sign_with_flag_a: assert property (rev_evt[1] |=> rev_flag[1] && phase_sign[1] == $past(sel_neg[1]))
    else $error("phase B sign bit not updated with its flag");
  sign_stable_a: assert property (!rev_evt[2] |=> $stable(phase_sign[2]))
    else $error("phase C sign changed without a reversal");
  irq_assert_a: assert property (rev_flag[0] && rev_mask[0] |=> !PRIMARY_INTERRUPT_N)
    else $error("masked-in flag did not pull interrupt low");
  w1c_clear_a: assert property (wr_status && REG_REQ.wdata[REV_LSB] && !rev_evt[0] |=> !rev_flag[0] ##1 (PRIMARY_INTERRUPT_N || $past(rev_flag[2:1] != 2'h0)))
    else $error("write one did not clear the flag or release interrupt");
  w0_keep_a: assert property (rev_flag[1] && !(wr_status && REG_REQ.wdata[REV_LSB+1]) |=> rev_flag[1])
    else $error("flag lost without a clearing write");
  tick_period_a: assert property (sample_en |=> !sample_en)
    else $error("sample tick longer than one cycle");
  read_answer_a: assert property (REG_REQ.rd |=> REG_RVALID)
    else $error("read not answered next cycle");

  // Remaining phases: phase C flag, phase A sign, phase C interrupt line and its release
  flag_c_set_a: assert property (rev_evt[2] |=> rev_flag[2])
    else $error("phase C reversal did not set its flag");
  sign_a_update_a: assert property (rev_evt[0] |=> phase_sign[0] == $past(sel_neg[0]))
    else $error("phase A sign bit not updated with its flag");
  irq_c_low_a: assert property (rev_flag[2] && rev_mask[2] |=> !PRIMARY_INTERRUPT_N)
    else $error("phase C flag did not pull interrupt low");
  irq_release_a: assert property (!(|(rev_flag & rev_mask)) |=> PRIMARY_INTERRUPT_N)
    else $error("interrupt low with no enabled flag");

  // Configuration writes land at their taking edge
  mask_write_a: assert property (REG_REQ.wr && REG_REQ.addr == ADDR_MASK |=> rev_mask == $past(REG_REQ.wdata[REV_LSB +: NPH]))
    else $error("mask write did not land");
  sel_write_a: assert property (REG_REQ.wr && REG_REQ.addr == ADDR_ACC_CFG |=> rev_sel == $past(REG_REQ.wdata[REVSEL_BIT]))
    else $error("select write did not land");
  thr_low_write_a: assert property (REG_REQ.wr && REG_REQ.addr == ADDR_THR_LOWER |=> thr[THR_HALF_W-1:0] == $past(REG_REQ.wdata[THR_HALF_W-1:0]))
    else $error("lower threshold write did not land");
  thr_up_write_a: assert property (REG_REQ.wr && REG_REQ.addr == ADDR_THR_UPPER |=> thr[THR_W-1:THR_HALF_W] == $past(REG_REQ.wdata[THR_HALF_W-1:0]))
    else $error("upper threshold write did not land");
  gain_write_a: assert property (REG_REQ.wr && REG_REQ.addr == ADDR_GAIN_BASE |=> gain[0] == {{(PWR_W-VAL_W){$past(REG_REQ.wdata[VAL_W-1])}}, $past(REG_REQ.wdata[VAL_W-1:0])})
    else $error("gain write not sign extended into place");

  // Read answer stands one cycle, data holds until the next read
  rvalid_pulse_a: assert property (!REG_REQ.rd |=> !REG_RVALID)
    else $error("read valid without a read");
  rdata_hold_a: assert property (!REG_REQ.rd |=> $stable(REG_RDATA))
    else $error("read data moved without a read");
  rev_c: cover property (rev_evt[0] ##[1:20] wr_status);
  fund_sel_c: cover property (rev_sel && sel_pulse[2]);
endmodule
`default_nettype wire

// ---- sim/aep_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host side of the register port
module aep_host (
  input wire logic clk,
  output aep_pkg::aep_reg_req_t req
);
  import aep_pkg::*;
  // Bus idles with no strobe until the first access
  initial req = '0;
  // One access: hold until the taking edge, then scramble the released lines
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    #1;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    @(posedge clk);
    #1;
  endtask
  // Status first, signs next, clear last, so the phase is known before it is lost
  task automatic service(input logic [2:0] clr);
    access(1'b0, ADDR_STATUS, WORD_ZERO);
    access(1'b0, ADDR_SIGN, WORD_ZERO);
    access(1'b1, ADDR_STATUS, {23'h0, clr, 6'h0});
  endtask
endmodule
`default_nettype wire

// ---- sim/aep_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module aep_top_tb;
  import aep_pkg::*;
  localparam int SC = 16;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  aep_power_t POWER = '0;
  wire aep_reg_req_t REG_REQ;
  wire logic [31:0] REG_RDATA;
  wire logic REG_RVALID;
  wire logic PRIMARY_INTERRUPT_N;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] exp_q[$];
  string name_q[$];
  longint acc[6] = '{default: 0};
  logic [31:0] cnt[6] = '{default: '0};
  logic [27:0] gn[6] = '{default: '0};
  logic [27:0] of[6] = '{default: '0};
  logic [47:0] thr = '0;
  logic [2:0] sgn = '0;
  logic [2:0] flg = '0;
  logic [2:0] msk = '0;
  logic sel = 1'b0;

  // ==========================================================
  // Clock, design and host
  always #12.5 CLK = ~CLK;
  aep_top #(.SAMPLE_CYCLES(SC)) aep_top_i (.CLK(CLK), .RST_N(RST_N), .POWER(POWER), .REG_REQ(REG_REQ),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .PRIMARY_INTERRUPT_N(PRIMARY_INTERRUPT_N));
  aep_host aep_host_i (.clk(CLK), .req(REG_REQ));

  // ==========================================================
  // Reference integration, stepped on the same edge as each sample tick
  always @(posedge CLK) begin
    longint p;
    longint a;
    int d;
    if (!RST_N) cyc = 0;
    else begin
      cyc++;
      if (cyc % SC == 0) begin
        for (int c = 0; c < 6; c++) begin
          p = (c < 3) ? longint'($signed(POWER.total[c % 3])) : longint'($signed(POWER.fund[c % 3]));
          a = acc[c] + p + ((p * longint'($signed(gn[c]))) >>> 23) + longint'($signed(of[c]));
          d = 2;
          if (a >= longint'(thr)) begin
            a = a - longint'(thr);
            cnt[c] = cnt[c] + 1;
            d = 0;
          end else if (a <= -longint'(thr)) begin
            a = a + longint'(thr);
            cnt[c] = cnt[c] - 1;
            d = 1;
          end
          acc[c] = a;
          if (d < 2 && (c >= 3) == sel && d[0] != sgn[c % 3]) begin
            sgn[c % 3] = d[0];
            flg[c % 3] = 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================
  // Compare tasks and read monitor
  task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_bit(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  // Each valid cycle answers the oldest outstanding read
  always @(negedge CLK) begin
    if (REG_RVALID === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("ERROR rvalid expected idle seen 1");
      end else check_word(name_q.pop_front(), exp_q.pop_front(), REG_RDATA);
    end
  end

  // ==========================================================
  // Bus tasks; accesses stay clear of tick edges so the model never races
  task automatic wait_safe(input int hi);
    while (cyc % SC < 4 || cyc % SC > hi) begin
      @(posedge CLK);
      #1;
    end
  endtask
  function automatic logic [31:0] expect_of(input logic [7:0] a);
    if (a < 8'h06) return {4'h0, gn[a]};
    if (a < 8'h0C) return {4'h0, of[a - 8'h06]};
    if (a >= ADDR_ENERGY_BASE && a < 8'h18) return cnt[a - ADDR_ENERGY_BASE];
    case (a)
      ADDR_THR_UPPER: return {8'h00, thr[47:24]};
      ADDR_THR_LOWER: return {8'h00, thr[23:0]};
      ADDR_SIGN: return {29'h0, sgn};
      ADDR_STATUS: return {23'h0, flg, 6'h0};
      ADDR_MASK: return {23'h0, msk, 6'h0};
      ADDR_ACC_CFG: return {25'h0, sel, 6'h0};
      default: return 32'h0;
    endcase
  endfunction
  task automatic rd(input logic [7:0] a);
    wait_safe(9);
    exp_q.push_back(expect_of(a));
    name_q.push_back($sformatf("reg_%h", a));
    aep_host_i.access(1'b0, a, WORD_ZERO);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wait_safe(9);
    aep_host_i.access(1'b1, a, d);
    if (a < 8'h06) gn[a] = {{4{d[23]}}, d[23:0]};
    else if (a < 8'h0C) of[a - 8'h06] = {{4{d[23]}}, d[23:0]};
    else if (a == ADDR_THR_UPPER) thr[47:24] = d[23:0];
    else if (a == ADDR_THR_LOWER) thr[23:0] = d[23:0];
    else if (a == ADDR_STATUS) flg = flg & ~d[8:6];
    else if (a == ADDR_MASK) msk = d[8:6];
    else if (a == ADDR_ACC_CFG) sel = d[6];
  endtask
  // Read status and signs, clear, then the line must be back high before the next tick
  task automatic irq_round();
    wait_safe(9);
    check_bit("irq_n", ~|(flg & msk), PRIMARY_INTERRUPT_N);
    wait_safe(4);
    exp_q.push_back(expect_of(ADDR_STATUS));
    name_q.push_back("status");
    exp_q.push_back(expect_of(ADDR_SIGN));
    name_q.push_back("sign");
    aep_host_i.service(flg);
    flg = '0;
    check_bit("irq_n", 1'b1, PRIMARY_INTERRUPT_N);
  endtask
  task automatic conclude();
    if (exp_q.size() != 0) begin
      err_count++;
      $display("ERROR pending_reads expected 0 seen %0d", exp_q.size());
    end
    $display("Checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // Watchdog, sized well above the nine hundred or so cycles the run needs
  initial begin
    #500000;
    err_count++;
    $display("ERROR watchdog expected done seen hang");
    conclude();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] v;
    void'($urandom(74638));
    repeat (4) @(posedge CLK);
    #1;
    RST_N = 1'b1;
    // Reset state of threshold, signs, flags, mask and select
    for (int a = 12; a < 18; a++) rd(a[7:0]);
    // Random calibration words, padded and sign extended
    for (int a = 0; a < 12; a++) begin
      v = $urandom();
      wr(a[7:0], {4'h0, {4{v[23]}}, v[23:0]});
      rd(a[7:0]);
    end
    // Read-only and unmapped words ignore writes
    wr(ADDR_SIGN, 32'h7);
    rd(ADDR_SIGN);
    wr(8'h30, 32'h1);
    rd(8'h30);
    // Threshold halves, largest upper bit kept clear so the value never goes negative
    wr(ADDR_THR_UPPER, 32'h00400001);
    rd(ADDR_THR_UPPER);
    wr(ADDR_THR_UPPER, 32'h0);
    wr(ADDR_THR_LOWER, 32'h000003E8);
    rd(ADDR_THR_LOWER);
    irq_round();
    // Half gain, one and a half gain and small offsets
    for (int c = 0; c < 12; c++) begin
      wr(c[7:0], (c == 0) ? 32'h0FC00000 : (c == 1) ? 32'h00400000 : (c == 8) ? 32'h5 : (c == 11) ? 32'h0FFFFFF9 : 32'h0);
    end
    wr(ADDR_MASK, 32'h000001C0);
    POWER.total[0] = 28'd400;
    POWER.total[1] = -28'sd500;
    POWER.total[2] = 28'd250;
    POWER.fund[0] = 28'd300;
    POWER.fund[1] = -28'sd200;
    POWER.fund[2] = 28'd700;
    repeat (20 * SC) @(posedge CLK);
    #1;
    for (int a = 18; a < 24; a++) rd(a[7:0]);
    irq_round();
    // Switch monitoring to fundamental power with only one phase unmasked
    wr(ADDR_MASK, 32'h00000080);
    wr(ADDR_ACC_CFG, 32'h00000040);
    POWER.fund[0] = -28'sd900;
    repeat (10 * SC) @(posedge CLK);
    #1;
    irq_round();
    for (int a = 18; a < 24; a++) rd(a[7:0]);
    repeat (4) @(posedge CLK);
    conclude();
  end
endmodule
`default_nettype wire
